// ===== rxo_regs.svh
`ifndef RXO_REGS_SVH
`define RXO_REGS_SVH
// register indices on the plain software port
`define RXO_ADDR_RX_CTRL     4'h0
`define RXO_ADDR_BLK_CTRL    4'h1
`define RXO_ADDR_STATUS      4'h2
// receive control fields
`define RXO_RXC_ON_BIT       0
`define RXO_RXC_EQ_BIT       1
`define RXO_RXC_INV_BIT      2
`define RXO_RXC_MON0_BIT     3
`define RXO_RXC_MON1_BIT     4
// block control fields
`define RXO_BLK_SR_BIT       0
// reset values
`define RXO_RX_CTRL_RST      8'h00
`define RXO_BLK_CTRL_RST     8'h00
`endif

// ===== rxo_pkg.sv
package rxo_pkg;
   // effective receive configuration
   typedef struct packed {
      logic rx_on;
      logic eq_on;
      logic clk_inv;
      logic monitor;
      logic single_rail;
   } rxo_cfg_t;

   // host-mode serial port pins
   typedef struct packed {
      logic serial_data_in;
      logic chip_select;
   } rxo_spi_t;
endpackage : rxo_pkg

// ===== rxo_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxo_regs.svh"
// How it works
// - hardware mode: receiver_on high powers and enables the receiver
// - host mode: receiver_on pin becomes serial_data_in
// - equalizer_enable high enables equalizer, low bypasses it
// - host mode ignores the equalizer_enable pin
// - recovered clock driven out; data changes on rising edge by default
// - hardware mode invert pin flips clock, data on falling edge
// - host mode invert bit set means data on falling edge
// - host mode: invert pin acts as serial chip select
// - positive output pulses once per positive line pulse
// - dual rail: negative output pulses per negative line pulse
// - host mode rail choice comes from block control bit
// - single rail: shared output pulses on code violation, else low
// - hardware mode monitor pin high selects monitoring channel
// - host mode monitor bits select monitoring channel
// - host mode: monitor pin becomes serial_data_out
// - mode select high means host, low means hardware
// - single rail enables line decoder, dual rail disables it
module rxo_top
   import rxo_pkg::*;
(
   // clock, reset, enable
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   // line side, already sliced, with its recovered clock
   input  wire logic       line_in_tip,
   input  wire logic       line_in_ring,
   input  wire logic       line_viol,
   input  wire logic       line_clk,
   // strap and dual-function pins
   input  wire logic       control_mode_select,
   input  wire logic       receiver_on,
   input  wire logic       equalizer_enable,
   input  wire logic       recovered_clock_invert,
   input  wire logic       rail_select,
   input  wire logic       monitor_mode_select,
   input  wire logic       serial_data_out_drv,
   // software register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // framer side
   output logic            recovered_clock_out,
   output logic            positive_pulse_out,
   output logic            negative_pulse_out,
   // analog controls and decoder enable
   output logic            rx_power_on,
   output logic            eq_enable_out,
   output logic            monitor_out,
   output logic            decoder_enable,
   // serial port pins in host mode
   output rxo_spi_t        spi_pins,
   output logic            serial_data_out,
   output logic            serial_data_out_oe
);

   // synchroniser pairs: tip, ring, viol, clk, mode, on, eq, inv, sr, mon
   localparam int NSYNC = 10;

   typedef struct packed {
      logic [NSYNC-1:0] s1;
      logic [NSYNC-1:0] s2;
      logic             clk_d;
      logic             host;
      logic [7:0]       rx_ctrl;
      logic [7:0]       blk_ctrl;
      logic [7:0]       rdata;
      logic             pos;
      logic             neg;
      logic             clk_o;
   } rxo_state_t;

   rxo_state_t st_r;
   rxo_state_t st_nxt;
   rxo_cfg_t   cfg;
   logic       edge_rise;
   logic       edge_fall;
   logic       upd;

   // register read decode, used for the read path
   function automatic logic [7:0] rd_mux(input logic [3:0] a,
                                          input rxo_state_t s,
                                          input rxo_cfg_t c);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `RXO_ADDR_RX_CTRL:  v = s.rx_ctrl;
         `RXO_ADDR_BLK_CTRL: v = s.blk_ctrl;
         `RXO_ADDR_STATUS:   v = {3'h0, c};
         default:            v = 8'h00;
      endcase
      return v;
   endfunction : rd_mux

   // synchronised pin views
   logic p_tip, p_ring, p_viol, p_clk;
   logic p_mode, p_on, p_eq, p_inv, p_sr, p_mon;
   assign {p_mon, p_sr, p_inv, p_eq, p_on,
           p_mode, p_clk, p_viol, p_ring, p_tip} = st_r.s2;

   // effective configuration from pins or registers
   always_comb
   begin
      if (st_r.host)
      begin
         cfg.monitor     = st_r.rx_ctrl[`RXO_RXC_MON0_BIT]
                         | st_r.rx_ctrl[`RXO_RXC_MON1_BIT];
         cfg.single_rail = st_r.blk_ctrl[`RXO_BLK_SR_BIT];
         cfg.eq_on       = st_r.rx_ctrl[`RXO_RXC_EQ_BIT];
         cfg.clk_inv     = st_r.rx_ctrl[`RXO_RXC_INV_BIT];
         cfg.rx_on       = st_r.rx_ctrl[`RXO_RXC_ON_BIT];
      end
      else
      begin
         cfg.monitor     = p_mon;
         cfg.single_rail = p_sr;
         cfg.eq_on       = p_eq;
         cfg.clk_inv     = p_inv;
         cfg.rx_on       = p_on;
      end
   end

   // line clock edges seen by the core clock
   assign edge_rise = p_clk & ~st_r.clk_d;
   assign edge_fall = ~p_clk & st_r.clk_d;
   assign upd = cfg.clk_inv ? edge_fall : edge_rise;

   // next-state logic
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = {monitor_mode_select, rail_select,
                   recovered_clock_invert, equalizer_enable, receiver_on,
                   control_mode_select, line_clk, line_viol,
                   line_in_ring, line_in_tip};
      st_nxt.s2 = st_r.s1;
      st_nxt.clk_d = p_clk;
      st_nxt.host = p_mode;
      if (reg_wr && reg_addr == `RXO_ADDR_RX_CTRL)
         st_nxt.rx_ctrl = reg_wdata;
      if (reg_wr && reg_addr == `RXO_ADDR_BLK_CTRL)
         st_nxt.blk_ctrl = reg_wdata;
      st_nxt.rdata = reg_rd ? rd_mux(reg_addr, st_r, cfg) : 8'h00;
      // recovered clock forwarded, flipped when inverted
      st_nxt.clk_o = p_clk ^ cfg.clk_inv;
      if (!cfg.rx_on)
      begin
         st_nxt.pos = 1'b0;
         st_nxt.neg = 1'b0;
      end
      else if (upd)
      begin
         st_nxt.pos = p_tip;
         st_nxt.neg = cfg.single_rail ? p_viol : p_ring;
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r          <= '0;
         st_r.rx_ctrl  <= `RXO_RX_CTRL_RST;
         st_r.blk_ctrl <= `RXO_BLK_CTRL_RST;
      end
      else if (clk_en)
         st_r <= st_nxt;
   end

   // outputs
   assign reg_rdata           = st_r.rdata;
   assign recovered_clock_out = st_r.clk_o;
   assign positive_pulse_out  = st_r.pos;
   assign negative_pulse_out  = st_r.neg;
   assign rx_power_on         = cfg.rx_on;
   assign eq_enable_out       = cfg.eq_on;
   assign monitor_out         = cfg.monitor;
   assign decoder_enable      = cfg.single_rail;
   assign spi_pins.serial_data_in = st_r.host & p_on;
   assign spi_pins.chip_select    = st_r.host & p_inv;
   assign serial_data_out     = serial_data_out_drv;
   assign serial_data_out_oe  = st_r.host;

   // assertions
   // receiver off keeps both pulse outputs quiet
   AST_OFF_QUIET: assert property (@(posedge core_clk) disable iff (!arst_n)
      clk_en && !cfg.rx_on |=> !positive_pulse_out && !negative_pulse_out)
      else $error("outputs active while receiver off");
   // positive output follows tip on update
   AST_POS: assert property (@(posedge core_clk) disable iff (!arst_n)
      clk_en && cfg.rx_on && upd |=> positive_pulse_out == $past(p_tip))
      else $error("positive output wrong");
   AST_VIOL: assert property (@(posedge core_clk) disable iff (!arst_n)
      clk_en && cfg.rx_on && upd && cfg.single_rail
      |=> negative_pulse_out == $past(p_viol))
      else $error("violation output wrong");
   AST_NEG: assert property (@(posedge core_clk) disable iff (!arst_n)
      clk_en && cfg.rx_on && upd && !cfg.single_rail
      |=> negative_pulse_out == $past(p_ring))
      else $error("negative output wrong");
   AST_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
      clk_en && cfg.rx_on && !upd |=> $stable(positive_pulse_out))
      else $error("data changed off edge");
   AST_EQ_HOST: assert property (@(posedge core_clk) disable iff (!arst_n)
      st_r.host |-> eq_enable_out == st_r.rx_ctrl[`RXO_RXC_EQ_BIT])
      else $error("equalizer pin not ignored");
   AST_EQ_HW: assert property (@(posedge core_clk) disable iff (!arst_n)
      !st_r.host |-> eq_enable_out == p_eq)
      else $error("equalizer not following pin");
   AST_DEC: assert property (@(posedge core_clk) disable iff (!arst_n)
      decoder_enable == cfg.single_rail)
      else $error("decoder mismatch");

   // synchronised line clock seen low then high on two enabled cycles
   sequence seq_lclk_rise;
      clk_en && !p_clk ##1 clk_en && p_clk;
   endsequence

   // synchronised line clock seen high then low on two enabled cycles
   sequence seq_lclk_fall;
      clk_en && p_clk ##1 clk_en && !p_clk;
   endsequence

   // receiver running with the default, non-inverted clock
   sequence seq_run_plain;
      cfg.rx_on && !cfg.clk_inv;
   endsequence

   // receiver running with the inverted clock
   sequence seq_run_inv;
      cfg.rx_on && cfg.clk_inv;
   endsequence

   // a rising line clock is found on the second cycle
   AST_RISE_SEEN: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      seq_lclk_rise |-> edge_rise)
      else $error("rising line clock edge missed");

   // a falling line clock is found on the second cycle
   AST_FALL_SEEN: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      seq_lclk_fall |-> edge_fall)
      else $error("falling line clock edge missed");

   // default clock: data taken from tip after a rising edge
   AST_RISE_DATA: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      seq_lclk_rise ##0 seq_run_plain
      |=> positive_pulse_out == $past(p_tip))
      else $error("data not updated on rising edge");

   // inverted clock: data taken from tip after a falling edge
   AST_FALL_DATA: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      seq_lclk_fall ##0 seq_run_inv
      |=> positive_pulse_out == $past(p_tip))
      else $error("data not updated on falling edge");

   // clock output follows the synced line clock and invert choice
   AST_CLK_OUT: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      clk_en |=> recovered_clock_out == ($past(p_clk) ^ $past(cfg.clk_inv)))
      else $error("recovered clock output wrong");

   // shared output holds between selected edges
   AST_NEG_HOLD: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      clk_en && cfg.rx_on && !upd |=> $stable(negative_pulse_out))
      else $error("negative output changed off edge");

   // mode flag follows the synced mode pin
   AST_MODE: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      clk_en |=> st_r.host == $past(p_mode))
      else $error("mode flag not following pin");

   // hardware mode: receiver power follows its pin
   AST_ON_HW: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      !st_r.host |-> rx_power_on == p_on)
      else $error("receiver power not following pin");

   // host mode: receiver power from bit, pin only feeds serial input
   AST_ON_HOST: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      st_r.host |-> rx_power_on == st_r.rx_ctrl[`RXO_RXC_ON_BIT]
                && spi_pins.serial_data_in == p_on)
      else $error("receiver pin misused in host mode");

   // chip select only in host mode
   AST_CS: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      spi_pins.chip_select == (st_r.host && p_inv))
      else $error("chip select wrong");

   // serial output driven only in host mode
   AST_SDO_OE: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      serial_data_out_oe == st_r.host)
      else $error("serial output enable wrong");

   AST_MON_HW: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      !st_r.host |-> monitor_out == p_mon)
      else $error("monitor not following pin");

   // host monitor from either control bit
   AST_MON_HOST: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      st_r.host |-> monitor_out == (st_r.rx_ctrl[`RXO_RXC_MON0_BIT]
                                  || st_r.rx_ctrl[`RXO_RXC_MON1_BIT]))
      else $error("monitor bits ignored");

   // block control write lands in the rail bit
   AST_WR_BLK: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      clk_en && reg_wr && reg_addr == `RXO_ADDR_BLK_CTRL
      |=> st_r.blk_ctrl == $past(reg_wdata))
      else $error("block control write lost");

   AST_WR_RXC: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      clk_en && reg_wr && reg_addr == `RXO_ADDR_RX_CTRL
      |=> st_r.rx_ctrl == $past(reg_wdata))
      else $error("receive control write lost");

   // read data stand only in the cycle after a read
   AST_RD_IDLE: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      clk_en && !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
endmodule : rxo_top
`default_nettype wire

// ===== rxo_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
module rxo_framer_model
(
   // recovered clock and data
   input  wire logic       rck,
   input  wire logic       pos,
   input  wire logic       clr,
   // tally of positive marks
   output logic      [7:0] pos_cnt
);
   always @(posedge rck or posedge clr)
   begin
      if (clr)
         pos_cnt <= 8'h00;
      else
         pos_cnt <= pos_cnt + {7'h00, pos};
   end
endmodule : rxo_framer_model
`default_nettype wire

// ===== tb_rxo_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rxo_top import rxo_pkg::*;;
   logic       core_clk, arst_n, line_clk, run, clr, v;
   logic       line_in_tip, line_in_ring, line_viol, control_mode_select;
   logic       receiver_on, equalizer_enable, recovered_clock_invert;
   logic       rail_select, monitor_mode_select, serial_data_out_drv;
   logic       reg_wr, reg_rd, recovered_clock_out, positive_pulse_out;
   logic       negative_pulse_out, rx_power_on, eq_enable_out;
   logic       monitor_out, decoder_enable, serial_data_out;
   logic       serial_data_out_oe;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv, pc;
   rxo_spi_t   spi_pins;
   int         mismatches, total_checks;

   rxo_top rxo_top_inst (.core_clk, .arst_n, .clk_en(1'b1), .line_in_tip,
      .line_in_ring, .line_viol, .line_clk, .control_mode_select,
      .receiver_on, .equalizer_enable, .recovered_clock_invert,
      .rail_select, .monitor_mode_select, .serial_data_out_drv, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .recovered_clock_out,
      .positive_pulse_out, .negative_pulse_out, .rx_power_on,
      .eq_enable_out, .monitor_out, .decoder_enable, .spi_pins,
      .serial_data_out, .serial_data_out_oe);
   rxo_framer_model rxo_framer_model_inst (.rck(recovered_clock_out),
      .pos(positive_pulse_out), .clr(clr), .pos_cnt(pc));

   // core clock and gated link clock
   always #25 core_clk = ~core_clk;
   always #200 line_clk = run ? ~line_clk : 1'b0;

   task automatic chk(input string nm, input logic [7:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   // watchdog
   initial
   begin
      #100000;
      mismatches++;
      report_and_stop();
   end

   // test sequence
   initial
   begin
      {core_clk, arst_n, line_clk, run, reg_wr, reg_rd} = 6'h00;
      {line_in_tip, line_in_ring, line_viol, control_mode_select} = 4'h0;
      {receiver_on, equalizer_enable, recovered_clock_invert} = 3'h0;
      {rail_select, monitor_mode_select, serial_data_out_drv} = 3'h0;
      {reg_addr, reg_wdata, clr, mismatches, total_checks} = 0;
      clr = 1'b1;
      cyc(2);
      {arst_n, clr} <= 2'b10;
      rd(4'h2, rv); chk("status", rv, 8'h00);
      rd(4'h7, rv); chk("unmapped", rv, 8'h00);
      $display("test reset done");
      {receiver_on, equalizer_enable, rail_select} <= 3'h7;
      monitor_mode_select <= 1'b1;
      cyc(8);
      v = {rx_power_on, eq_enable_out, monitor_out, decoder_enable} === 4'hf;
      chk("hw cfg", {7'h00, v}, 8'h01);
      chk("oe", {7'h00, serial_data_out_oe}, 8'h00);
      rd(4'h2, rv); chk("hw status", rv, 8'h1b);
      {equalizer_enable, rail_select, monitor_mode_select} <= 3'h0;
      cyc(8);
      v = {rx_power_on, eq_enable_out, monitor_out, decoder_enable} === 4'h8;
      chk("hw cfg2", {7'h00, v}, 8'h01);
      $display("test hw config done");
      {line_in_tip, line_in_ring, run} <= 3'h7;
      cyc(40);
      chk("dual", {6'h00, positive_pulse_out, negative_pulse_out}, 8'h03);
      chk("framer", {7'h00, pc > 8'h02}, 8'h01);
      rail_select <= 1'b1; // strap high for single rail
      cyc(40);
      chk("no viol", {7'h00, negative_pulse_out}, 8'h00);
      line_viol <= 1'b1;
      cyc(40);
      chk("viol", {7'h00, negative_pulse_out}, 8'h01);
      receiver_on <= 1'b0;
      cyc(40);
      chk("rx off", {6'h00, positive_pulse_out, negative_pulse_out}, 8'h00);
      $display("test data done");
      {run, recovered_clock_invert} <= 2'b01;
      cyc(20);
      chk("inv clk", {7'h00, recovered_clock_out}, 8'h01);
      recovered_clock_invert <= 1'b0;
      cyc(8);
      chk("clk", {7'h00, recovered_clock_out}, 8'h00);
      $display("test clock done");
      {control_mode_select, receiver_on, equalizer_enable} <= 3'h7;
      {recovered_clock_invert, serial_data_out_drv} <= 2'h3;
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h0c);
      cyc(8);
      v = {rx_power_on, eq_enable_out, monitor_out, decoder_enable} === 4'h2;
      chk("host cfg", {7'h00, v}, 8'h01);
      chk("spi", {4'h0, spi_pins, serial_data_out, serial_data_out_oe}, 8'h0f);
      chk("host clk", {7'h00, recovered_clock_out}, 8'h01);
      rd(4'h2, rv); chk("host st", rv, 8'h06);
      wr(4'h0, 8'h11);
      wr(4'h1, 8'h01);
      cyc(8);
      rd(4'h2, rv); chk("host st2", rv, 8'h13);
      chk("decoder", {7'h00, decoder_enable}, 8'h01);
      $display("test host done");
      report_and_stop();
   end
endmodule : tb_rxo_top
`default_nettype wire
